/* File: logic/twsm_pkg.sv */
package twsm_pkg;

   // Byte offsets of the register map
   localparam logic [4:0] OFF_CFG   = 5'h00; // comm_config_reg
   localparam logic [4:0] OFF_MODE  = 5'h04; // serial_mode_reg
   localparam logic [4:0] OFF_DATA  = 5'h08; // serial_data_buffer_reg
   localparam logic [4:0] OFF_STAT  = 5'h0C; // serial_status_reg
   localparam logic [4:0] OFF_DIV   = 5'h10;
   localparam logic [4:0] OFF_PCE   = 5'h14; // peripheral_clock_enable_reg
   localparam logic [4:0] OFF_ISTAT = 5'h18;
   localparam logic [4:0] OFF_IMASK = 5'h1C;

   // Field positions
   localparam int CFG_TXE    = 0;
   localparam int CFG_RXE    = 1;
   localparam int CFG_DAP    = 2;
   localparam int CFG_CKP    = 3;
   localparam int CFG_MSB    = 4;
   localparam int CFG_LEN_LO = 8;
   localparam int MODE_ISEL  = 0;
   localparam int STAT_BFF   = 0;
   localparam int STAT_BUSY  = 1;
   localparam int STAT_OVF   = 2;
   localparam int STAT_RXV   = 3;
   localparam int IRQ_EVT    = 0;
   localparam int IRQ_OVF    = 1;

   // Word length held as length minus one, 7 to 16 bits
   localparam logic [3:0]  LEN_M1_MIN = 4'h6;
   localparam int          DIV_W      = 11;
   localparam logic [10:0] DIV_RST    = 11'h000;

   typedef struct packed {
      logic       txe;
      logic       rxe;
      logic       dap;
      logic       ckp;
      logic       msb;
      logic [3:0] len_m1;
   } twsm_cfg_t;

   localparam twsm_cfg_t CFG_RST = '{txe: 1'b0, rxe: 1'b0, dap: 1'b0,
                                     ckp: 1'b0, msb: 1'b1, len_m1: 4'h7};

   typedef enum logic {ST_IDLE, ST_SHIFT} twsm_state_t;

endpackage

/* File: logic/twsm_sync.sv */
module twsm_sync (
   input  wire logic clock, // System clock
   input  wire logic rst,   // Async reset, active high
   input  wire logic d,     // Level from outside the domain
   output logic      q      // Synchronised level
);
   logic meta;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         meta <= 1'b0;
         q    <= 1'b0;
      end else begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule

/* File: logic/twsm_top.sv */
// Functional notes
// - Data write while buffer full replaces the buffered transmit word.
// - Interrupt source select may change mid-transfer without stopping channel.
// - Master drives the serial clock itself and captures slave data.
// - One interrupt: transfer end or buffer empty, chosen by select bit. Here receive overflow also raises it when unmasked.
// - Receive overflow is the only error detected and flagged.
//
// Our own choices: register access over Avalon-MM and the address map.
module twsm_top
   import twsm_pkg::*;
(
   input  wire logic        clock,                    // 20 MHz system clock
   input  wire logic        rst,                      // Async reset
   input  wire logic [4:0]  address,                  // Byte address
   input  wire logic        read,                     // Read request
   input  wire logic        write,                    // Write request
   input  wire logic [31:0] writedata,                // Write data
   output logic      [31:0] readdata,                 // Read data
   output logic             waitrequest,              // Stall
   output logic             serial_clock_pin,         // Serial clock out
   output logic             serial_data_out_pin,      // Serial data out
   input  wire logic        serial_data_in_pin,       // Serial data in
   output logic             serial_channel_interrupt  // Level interrupt
);
   import twsm_pkg::*;

   function automatic logic out_bit(logic [15:0] w, logic [3:0] lm1,
                                    logic msb);
      return msb ? w[lm1] : w[0];
   endfunction

   function automatic logic [15:0] rx_in(logic [15:0] r, logic b,
                                         logic msb);
      return msb ? {r[14:0], b} : {b, r[15:1]};
   endfunction

   logic             sdi;
   twsm_cfg_t        cfg, next_cfg;
   logic             isel, next_isel;
   logic [10:0]      div, next_div;
   logic             pce, next_pce;
   logic [15:0]      buf_word, next_buf_word;
   logic             bff, next_bff;
   twsm_state_t      st, next_st;
   logic             half, next_half;
   logic [10:0]      cnt, next_cnt;
   logic [3:0]       bitn, next_bitn;
   logic [15:0]      tx_sh, next_tx_sh;
   logic [15:0]      rx_sh, next_rx_sh;
   logic [15:0]      rx_word, next_rx_word;
   logic             rxv, next_rxv;
   logic             ovf, next_ovf;
   logic [1:0]       ist, next_ist;
   logic [1:0]       imask, next_imask;
   logic             sclk, next_sclk;
   logic             sdo, next_sdo;
   logic             irq, next_irq;
   logic [31:0]      next_readdata;
   logic             next_wait;
   logic             w_en, r_en, ev_end, ev_empty, ev_ovf, chan_evt;
   logic             ovf_clr;
   logic [1:0]       ist_clr;
   logic [15:0]      rx_tmp, sh;

   // Serial input crosses from the slave's timing
   twsm_sync u_sync (
      .clock (clock),
      .rst   (rst),
      .d     (serial_data_in_pin),
      .q     (sdi)
   );

   assign w_en = write && !waitrequest;
   // Read is taken as the answer is built, so flag and data agree
   assign r_en = read && waitrequest;

   // Bus handshake: one wait cycle, then the answer
   always_comb begin
      next_wait     = 1'b1;
      next_readdata = readdata;
      if ((read || write) && waitrequest) begin
         next_wait     = 1'b0;
         next_readdata = 32'h0000_0000;
         if (read) begin
            case (address)
               OFF_CFG: begin
                  next_readdata[CFG_TXE] = cfg.txe;
                  next_readdata[CFG_RXE] = cfg.rxe;
                  next_readdata[CFG_DAP] = cfg.dap;
                  next_readdata[CFG_CKP] = cfg.ckp;
                  next_readdata[CFG_MSB] = cfg.msb;
                  next_readdata[CFG_LEN_LO +: 4] = cfg.len_m1;
               end
               OFF_MODE:  next_readdata[MODE_ISEL] = isel;
               OFF_DATA:  next_readdata[15:0] = rx_word;
               OFF_STAT: begin
                  next_readdata[STAT_BFF]  = bff;
                  next_readdata[STAT_BUSY] = (st == ST_SHIFT);
                  next_readdata[STAT_OVF]  = ovf;
                  next_readdata[STAT_RXV]  = rxv;
               end
               OFF_DIV:   next_readdata[DIV_W-1:0] = div;
               OFF_PCE:   next_readdata[0] = pce;
               OFF_ISTAT: next_readdata[1:0] = ist;
               OFF_IMASK: next_readdata[1:0] = imask;
               default:   next_readdata = 32'h0000_0000;
            endcase
         end
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         waitrequest <= 1'b1;
         readdata    <= 32'h0000_0000;
      end else begin
         waitrequest <= next_wait;
         readdata    <= next_readdata;
      end
   end

   // Channel core
   always_comb begin
      next_cfg      = cfg;
      next_isel     = isel;
      next_div      = div;
      next_pce      = pce;
      next_buf_word = buf_word;
      next_bff      = bff;
      next_st       = st;
      next_half     = half;
      next_cnt      = cnt;
      next_bitn     = bitn;
      next_tx_sh    = tx_sh;
      next_rx_sh    = rx_sh;
      next_rx_word  = rx_word;
      next_rxv      = rxv;
      next_imask    = imask;
      next_sclk     = sclk;
      next_sdo      = sdo;
      ev_end        = 1'b0;
      ev_empty      = 1'b0;
      ev_ovf        = 1'b0;
      ovf_clr       = 1'b0;
      ist_clr       = 2'b00;
      rx_tmp        = rx_sh;
      sh            = tx_sh;
      // Read clears first so a word finishing now still sets the flag
      if (r_en && address == OFF_DATA)
         next_rxv = 1'b0;

      case (st)
         ST_IDLE: begin
            next_sclk = cfg.ckp;
            if (bff && (cfg.txe || cfg.rxe)) begin
               next_tx_sh = buf_word;
               next_bff   = 1'b0;
               ev_empty   = 1'b1;
               next_rx_sh = 16'h0000;
               next_bitn  = 4'h0;
               next_half  = 1'b0;
               next_cnt   = div;
               next_st    = ST_SHIFT;
               if (!cfg.dap)
                  next_sdo = out_bit(buf_word, cfg.len_m1, cfg.msb);
            end
         end
         ST_SHIFT: begin
            if (cnt != 11'h000) begin
               next_cnt = cnt - 11'h001;
            end else begin
               next_cnt  = div;
               next_sclk = ~sclk;
               if (!half) begin
                  next_half = 1'b1;
                  if (cfg.dap)
                     next_sdo = out_bit(tx_sh, cfg.len_m1, cfg.msb);
                  else
                     next_rx_sh = rx_in(rx_sh, sdi, cfg.msb);
               end else begin
                  next_half = 1'b0;
                  if (cfg.dap)
                     rx_tmp = rx_in(rx_sh, sdi, cfg.msb);
                  sh = cfg.msb ? {tx_sh[14:0], 1'b0} : {1'b0, tx_sh[15:1]};
                  next_rx_sh = rx_tmp;
                  next_tx_sh = sh;
                  if (!cfg.dap)
                     next_sdo = out_bit(sh, cfg.len_m1, cfg.msb);
                  if (bitn == cfg.len_m1) begin
                     ev_end = 1'b1;
                     if (cfg.rxe) begin
                        ev_ovf       = next_rxv;
                        next_rxv     = 1'b1;
                        next_rx_word = cfg.msb ? rx_tmp :
                           rx_tmp >> (4'hF - cfg.len_m1);
                     end
                     // Continuous: a waiting word starts with no gap
                     if (bff) begin
                        next_tx_sh = buf_word;
                        next_bff   = 1'b0;
                        ev_empty   = 1'b1;
                        next_rx_sh = 16'h0000;
                        next_bitn  = 4'h0;
                        if (!cfg.dap)
                           next_sdo = out_bit(buf_word, cfg.len_m1,
                                              cfg.msb);
                     end else begin
                        next_st = ST_IDLE;
                     end
                  end else begin
                     next_bitn = bitn + 4'h1;
                  end
               end
            end
         end
         default: next_st = ST_IDLE;
      endcase

      // Bus side after the core so a write beside a load is kept
      if (w_en) begin
         case (address)
            OFF_PCE: next_pce = writedata[0];
            OFF_CFG: begin
               // Frame format is held steady while shifting
               if (pce && st == ST_IDLE) begin
                  next_cfg.txe = writedata[CFG_TXE];
                  next_cfg.rxe = writedata[CFG_RXE];
                  next_cfg.dap = writedata[CFG_DAP];
                  next_cfg.ckp = writedata[CFG_CKP];
                  next_cfg.msb = writedata[CFG_MSB];
                  next_cfg.len_m1 =
                     (writedata[CFG_LEN_LO +: 4] < LEN_M1_MIN) ?
                     LEN_M1_MIN : writedata[CFG_LEN_LO +: 4];
               end
            end
            OFF_MODE: if (pce) next_isel = writedata[MODE_ISEL];
            OFF_DATA: begin
               if (pce) begin
                  next_buf_word = writedata[15:0];
                  next_bff      = 1'b1;
               end
            end
            OFF_DIV:   if (pce) next_div = writedata[DIV_W-1:0];
            OFF_STAT:  ovf_clr = writedata[STAT_OVF];
            OFF_ISTAT: ist_clr = writedata[1:0];
            OFF_IMASK: next_imask = writedata[1:0];
            default: ;
         endcase
      end

      chan_evt = isel ? ev_empty : ev_end;
      // Setting wins over a clear in the same cycle
      next_ovf = (ovf && !ovf_clr) || ev_ovf;
      next_ist = (ist & ~ist_clr) | {ev_ovf, chan_evt};
      if (!cfg.txe)
         next_sdo = 1'b0;

      // Clock removed: channel returns to its reset state, save received word, buffered word, shift registers, divider count, interrupt status and mask
      if (!next_pce) begin
         next_cfg      = CFG_RST;
         next_isel     = 1'b0;
         next_div      = DIV_RST;
         next_bff      = 1'b0;
         next_st       = ST_IDLE;
         next_half     = 1'b0;
         next_bitn     = 4'h0;
         next_rxv      = 1'b0;
         next_ovf      = 1'b0;
         next_sclk     = CFG_RST.ckp;
         next_sdo      = 1'b0;
      end
      next_irq = |(next_ist & next_imask);
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         cfg      <= CFG_RST;
         isel     <= 1'b0;
         div      <= DIV_RST;
         pce      <= 1'b0;
         buf_word <= 16'h0000;
         bff      <= 1'b0;
         st       <= ST_IDLE;
         half     <= 1'b0;
         cnt      <= 11'h000;
         bitn     <= 4'h0;
         tx_sh    <= 16'h0000;
         rx_sh    <= 16'h0000;
         rx_word  <= 16'h0000;
         rxv      <= 1'b0;
         ovf      <= 1'b0;
         ist      <= 2'b00;
         imask    <= 2'b00;
         sclk     <= 1'b0;
         sdo      <= 1'b0;
         irq      <= 1'b0;
      end else begin
         cfg      <= next_cfg;
         isel     <= next_isel;
         div      <= next_div;
         pce      <= next_pce;
         buf_word <= next_buf_word;
         bff      <= next_bff;
         st       <= next_st;
         half     <= next_half;
         cnt      <= next_cnt;
         bitn     <= next_bitn;
         tx_sh    <= next_tx_sh;
         rx_sh    <= next_rx_sh;
         rx_word  <= next_rx_word;
         rxv      <= next_rxv;
         ovf      <= next_ovf;
         ist      <= next_ist;
         imask    <= next_imask;
         sclk     <= next_sclk;
         sdo      <= next_sdo;
         irq      <= next_irq;
      end
   end

   assign serial_clock_pin         = sclk;
   assign serial_data_out_pin      = sdo;
   assign serial_channel_interrupt = irq;

   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   property p_bff_replace;
      w_en && address == OFF_DATA && pce && next_pce
         |=> bff && buf_word == $past(writedata[15:0]);
   endproperty
   a_bff_replace: assert property (p_bff_replace)
      else $error("buffered word not replaced");

   property p_isel_live;
      w_en && address == OFF_MODE && pce && st == ST_SHIFT
         && cnt != 11'h000
         |=> st == ST_SHIFT && isel == $past(writedata[MODE_ISEL]);
   endproperty
   a_isel_live: assert property (p_isel_live)
      else $error("select change disturbed transfer");

   property p_sclk_rate;
      st == ST_SHIFT && cnt != 11'h000 && next_pce |=> $stable(sclk);
   endproperty
   a_sclk_rate: assert property (p_sclk_rate)
      else $error("serial clock toggled early");

   property p_idle_clk;
      ((st == ST_IDLE) [*2]) ##0 $stable(cfg) |-> sclk == cfg.ckp;
   endproperty
   a_idle_clk: assert property (p_idle_clk)
      else $error("idle clock level wrong");

   property p_rx_done;
      ev_end && cfg.rxe && next_pce |=> rxv;
   endproperty
   a_rx_done: assert property (p_rx_done)
      else $error("received word not flagged");

   property p_ovf_set;
      ev_ovf && next_pce |=> ovf && ist[IRQ_OVF];
   endproperty
   a_ovf_set: assert property (p_ovf_set)
      else $error("overflow not flagged");

   property p_ovf_cause;
      $rose(ovf) |-> $past(rxv) && $past(ev_end);
   endproperty
   a_ovf_cause: assert property (p_ovf_cause)
      else $error("overflow without unread word");

   property p_irq_end;
      ev_end && !isel && imask[IRQ_EVT] && next_imask[IRQ_EVT]
         |=> serial_channel_interrupt;
   endproperty
   a_irq_end: assert property (p_irq_end)
      else $error("transfer end interrupt missing");

   property p_irq_empty;
      ev_empty && isel && next_pce |=> ist[IRQ_EVT];
   endproperty
   a_irq_empty: assert property (p_irq_empty)
      else $error("buffer empty event missing");

   c_continuous: cover property (ev_end && ev_empty);
   c_overflow:   cover property (ev_ovf);
   c_isel_shift: cover property (p_isel_live);
endmodule

/* File: sim/twsm_slave.sv */
module twsm_slave (
   input  wire logic        sclk,    // Serial clock from master
   input  wire logic        sdo,     // Master data out
   input  wire logic        ckp,     // Idle level of the clock
   input  wire logic        dap,     // Phase select
   input  wire logic        start,   // Rising edge arms a frame
   input  wire logic [15:0] tx_bits, // Bits to send, in send order
   output logic             sdi,     // Data to master
   output logic      [31:0] rx_bits, // Bits seen, in arrival order
   output int               rx_cnt   // Number of bits seen
);
   timeunit 1ns;
   timeprecision 1ns;

   int idx = -1;

   initial begin
      rx_cnt = 0;
      rx_bits = '0;
   end

   // Phase 1 presents the first bit on the leading edge, not before it
   always @(posedge start) begin
      idx = dap ? -1 : 0;
      rx_cnt = 0;
      rx_bits = '0;
   end

   // Outside a word the line toggles, so a stale bit is never read as good
   assign sdi = (idx >= 0 && idx < 16) ? tx_bits[idx[3:0]] : idx[0];

   always @(sclk) begin
      if (sclk === (ckp ~^ dap)) begin
         if (rx_cnt < 32) rx_bits[rx_cnt[4:0]] = sdo;
         rx_cnt++;
      end else begin
         idx++;
      end
   end
endmodule

/* File: sim/test_three_wire_serial_master.sv */
module test_three_wire_serial_master;
   timeunit 1ns;
   timeprecision 1ns;
   import twsm_pkg::*;

   logic        clock = 1'b0;
   logic        rst = 1'b1;
   logic [4:0]  address = 5'h00;
   logic        read = 1'b0;
   logic        write = 1'b0;
   logic [31:0] writedata = 32'h0;
   logic [31:0] readdata;
   logic        waitrequest;
   logic        sclk;
   logic        sdo;
   logic        sdi;
   logic        irq;
   logic        s_ckp = 1'b0;
   logic        s_dap = 1'b0;
   logic        s_start = 1'b0;
   logic [15:0] s_tx = 16'h0;
   logic [31:0] s_rx;
   int          s_cnt;
   int          fail_count = 0;
   int          num_checks = 0;
   int          cyc = 0;

   always #25 clock = ~clock;

   twsm_top u_dut (
      .clock                    (clock),
      .rst                      (rst),
      .address                  (address),
      .read                     (read),
      .write                    (write),
      .writedata                (writedata),
      .readdata                 (readdata),
      .waitrequest              (waitrequest),
      .serial_clock_pin         (sclk),
      .serial_data_out_pin      (sdo),
      .serial_data_in_pin       (sdi),
      .serial_channel_interrupt (irq)
   );

   twsm_slave u_slave (
      .sclk    (sclk),
      .sdo     (sdo),
      .ckp     (s_ckp),
      .dap     (s_dap),
      .start   (s_start),
      .tx_bits (s_tx),
      .sdi     (sdi),
      .rx_bits (s_rx),
      .rx_cnt  (s_cnt)
   );

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // Ceiling well above the thousand or so cycles the run needs
   always @(posedge clock) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         end_of_test();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      @(posedge clock);
      address <= a;
      writedata <= d;
      write <= 1'b1;
      do @(posedge clock); while (waitrequest !== 1'b0);
      write <= 1'b0;
   endtask

   task automatic rd(input logic [4:0] a, output logic [31:0] d);
      @(posedge clock);
      address <= a;
      read <= 1'b1;
      do @(posedge clock); while (waitrequest !== 1'b0);
      d = readdata;
      read <= 1'b0;
   endtask

   task automatic wait_bit(input int b, input logic v);
      logic [31:0] d;
      rd(OFF_STAT, d);
      while (d[b] !== v) rd(OFF_STAT, d);
   endtask

   task automatic setup(input logic ckp, dap, msb, input logic [3:0] lm1,
                        input logic [15:0] s);
      wr(OFF_PCE, 32'h1);
      wr(OFF_DIV, 32'h3);
      wr(OFF_MODE, 32'h0);
      wr(OFF_IMASK, 32'h3);
      wr(OFF_CFG, {20'h0, lm1, 3'h0, msb, ckp, dap, 2'h3});
      wr(OFF_ISTAT, 32'h3);
      s_ckp <= ckp;
      s_dap <= dap;
      s_tx <= s;
      s_start <= 1'b1;
      @(posedge clock);
      s_start <= 1'b0;
   endtask

   task automatic xfer(input logic ckp, dap, msb, input logic [3:0] lm1,
                       input logic [15:0] w, s);
      logic [31:0] d;
      logic [31:0] e;
      int n;
      int p;
      setup(ckp, dap, msb, lm1, s);
      wr(OFF_DATA, {16'h0, w});
      wait_bit(STAT_BUSY, 1'b0);
      n = lm1 + 1;
      e = '0;
      for (int i = 0; i < n; i++) begin
         p = msb ? n - 1 - i : i;
         chk(32'(s_rx[i]), 32'(w[p]));
         e[p] = s[i];
      end
      chk(32'(s_cnt), 32'(n));
      chk(32'(sclk), 32'(ckp));
      rd(OFF_DATA, d);
      chk(d, e);
      chk(32'(irq), 32'h1);
      wr(OFF_ISTAT, 32'h1);
      @(posedge clock);
      chk(32'(irq), 32'h0);
   endtask

   task automatic cont_test;
      logic [31:0] d;
      setup(1'b0, 1'b0, 1'b1, 4'h7, 16'h0);
      wr(OFF_MODE, 32'h1);
      wr(OFF_DATA, 32'h3C);
      wr(OFF_DATA, 32'h81);
      wr(OFF_DATA, 32'hD2);
      rd(OFF_STAT, d);
      chk(32'(d[STAT_BFF]), 32'h1);
      wait_bit(STAT_BFF, 1'b0);
      rd(OFF_ISTAT, d);
      chk(32'(d[IRQ_EVT]), 32'h1);
      wr(OFF_ISTAT, 32'h1);
      wr(OFF_MODE, 32'h0);
      rd(OFF_STAT, d);
      chk(32'(d[STAT_BUSY]), 32'h1);
      wait_bit(STAT_BUSY, 1'b0);
      rd(OFF_ISTAT, d);
      chk(d, 32'h3);
      rd(OFF_STAT, d);
      chk(32'(d[STAT_OVF]), 32'h1);
      chk(32'(s_cnt), 32'd16);
      chk({24'h0, s_rx[8], s_rx[9], s_rx[10], s_rx[11], s_rx[12], s_rx[13],
           s_rx[14], s_rx[15]}, 32'hD2);
   endtask

   task automatic abort_test;
      logic [31:0] d;
      setup(1'b1, 1'b0, 1'b1, 4'h7, 16'h0);
      wr(OFF_DATA, 32'h55);
      repeat (10) @(posedge clock);
      wr(OFF_PCE, 32'h0);
      rd(OFF_STAT, d);
      chk(32'(d[STAT_BUSY]), 32'h0);
      rd(OFF_CFG, d);
      chk(d, 32'h710);
      chk(32'(sclk), 32'h0);
      xfer(1'b0, 1'b0, 1'b1, 4'h7, 16'h96, 16'h00F0);
   endtask

   initial begin
      repeat (4) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      chk({29'h0, waitrequest, sclk, irq}, 32'h4);
      xfer(1'b0, 1'b0, 1'b1, 4'h7, 16'hA5, 16'h00C3);
      xfer(1'b0, 1'b1, 1'b0, 4'h6, 16'h4B, 16'h0059);
      xfer(1'b1, 1'b0, 1'b1, 4'hF, 16'hB38E, 16'h6D1A);
      xfer(1'b1, 1'b1, 1'b0, 4'hB, 16'h0A6C, 16'h0E53);
      cont_test();
      abort_test();
      end_of_test();
   end
endmodule
